// ---- include/qsc_params.svh ----
`ifndef QSC_PARAMS_SVH
`define QSC_PARAMS_SVH

// register byte offsets
`define QSC_OFF_CTRL      12'h000
`define QSC_OFF_SPAN      12'h004
`define QSC_OFF_STATUS    12'h008
`define QSC_OFF_RESULT0   12'h010

// control fields
`define QSC_CTRL_PDOWN_BIT  0
`define QSC_CTRL_LANE_LSB   2
`define QSC_CTRL_LANE_MSB   3
`define QSC_CTRL_RESET      32'h0000_0000
`define QSC_SPAN_RESET      12'hFFF

// status fields
`define QSC_STAT_BUSY_BIT   0
`define QSC_STAT_LVDS_BIT   1
`define QSC_STAT_READY_BIT  2

// result word fields
`define QSC_RES_SPAN_LSB    16
`define QSC_RES_SPAN_MSB    18

// span code and conversion code constants
`define QSC_SPAN_OFF        3'h0
`define QSC_SIGN_FLIP       16'h8000
`define QSC_FIRST_TRIAL     16'h8000

// timing
`define QSC_CLK_NS          4
`define QSC_SETTLE_NS       12
`define QSC_SYNC_STAGES     2
`define QSC_SETTLE_CYC \
   ((`QSC_SETTLE_NS + `QSC_CLK_NS - 1) / `QSC_CLK_NS + `QSC_SYNC_STAGES)

`endif

// ---- include/qsc_pkg.sv ----
/*
 Types shared by the quad converter sequencer.
 Assumes qsc_params.svh holds the numeric constants.
*/
package qsc_pkg;

   typedef logic [2:0] qsc_span_t;

   typedef enum logic [2:0] {
      QSC_ST_ACQ    = 3'b000,
      QSC_ST_PICK   = 3'b001,
      QSC_ST_WAIT   = 3'b010,
      QSC_ST_DECIDE = 3'b011,
      QSC_ST_SEND   = 3'b100
   } qsc_state_t;

   typedef struct packed {
      logic [1:0] chan;
      qsc_span_t  span;
      logic [15:0] code;
   } qsc_word_t;

endpackage

// ---- design/qsc_sequencer.sv ----
/*
 Conversion sequencer of a four-channel simultaneous-sampling 16-bit
 successive-approximation converter, with an APB register slave and a
 two-entry output buffer toward the serial shifter.
 Assumes an external comparator and shared converter array, and a serial
 shifter downstream that drains the output stream with valid/ready.
*/
`timescale 1ns/1ps
`include "qsc_params.svh"

module qsc_sequencer #(
   parameter int NUM_CH  = 4,
   parameter int CODE_W  = 16,
   parameter int BUF_DEP = 2
) (
   // clock and reset
   input  wire logic              I_CLOCK,
   input  wire logic              I_RESETN,
   // apb slave
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [11:0]       I_PADDR,
   input  wire logic [31:0]       I_PWDATA,
   output logic      [31:0]       O_PRDATA,
   output logic                   O_PREADY,
   output logic                   O_PSLVERR,
   // pins
   input  wire logic              I_CONV_START,
   input  wire logic              I_LVDS_SEL,
   input  wire logic              I_CMP_HIGH,
   // converter array control
   output logic      [NUM_CH-1:0] O_HOLD,
   output logic      [1:0]        O_CH_SEL,
   output logic                   O_CH_ATTACH,
   output logic      [CODE_W-1:0] O_DAC_CODE,
   output logic                   O_POWER_DOWN,
   // output stream
   output logic                   O_OUT_VALID,
   input  wire logic              I_OUT_READY,
   output qsc_pkg::qsc_word_t     O_OUT_WORD,
   output logic                   O_LVDS_MODE,
   output logic      [2:0]        O_LANE_COUNT
);

   localparam int SETTLE_CYC = `QSC_SETTLE_CYC;

   qsc_pkg::qsc_state_t state_r;
   logic [2:0]        start_sync_r;
   logic [1:0]        lvds_sync_r;
   logic [1:0]        cmp_sync_r;
   logic              pdown_r;
   logic [1:0]        lane_m1_r;
   logic [11:0]       span_word_r;
   logic              ready_r;
   logic [11:0]       span_lat_r;
   logic [2:0]        ch_r;
   logic [3:0]        bit_r;
   logic [CODE_W-1:0] code_r;
   logic [7:0]        wait_r;
   logic              hold_r;
   logic [CODE_W-1:0] work_r [NUM_CH];
   logic [CODE_W-1:0] res_r  [NUM_CH];
   logic [2:0]        res_span_r [NUM_CH];
   logic              commit;
   logic [1:0]        send_r;
   logic [31:0]       prdata_r;
   logic              start_edge;
   logic              cmp_s;
   qsc_pkg::qsc_span_t cur_span;
   logic              wr_acc;
   logic              addr_ok;
   // output buffer
   qsc_pkg::qsc_word_t buf_mem [BUF_DEP];
   logic              buf_wp_r;
   logic              buf_rp_r;
   logic [1:0]        buf_cnt_r;
   logic              buf_push;
   logic              buf_pop;
   logic              buf_in_ready;
   qsc_pkg::qsc_word_t buf_in;

   // pin synchronisers, edge taken from the second and third stages
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         start_sync_r <= 3'h0;
         lvds_sync_r  <= 2'h0;
         cmp_sync_r   <= 2'h0;
      end else begin
         start_sync_r <= {start_sync_r[1:0], I_CONV_START};
         lvds_sync_r  <= {lvds_sync_r[0], I_LVDS_SEL};
         cmp_sync_r   <= {cmp_sync_r[0], I_CMP_HIGH};
      end
   end

   assign start_edge = start_sync_r[1] & ~start_sync_r[2];
   assign cmp_s      = cmp_sync_r[1];
   assign cur_span   = span_lat_r[ch_r[1:0]*3 +: 3];
   assign commit     = (state_r == qsc_pkg::QSC_ST_PICK) &&
                       (ch_r == 3'(NUM_CH));

   // apb decode
   assign wr_acc  = I_PSEL & I_PENABLE & I_PWRITE;
   assign addr_ok = (I_PADDR == `QSC_OFF_CTRL) ||
                    (I_PADDR == `QSC_OFF_SPAN) ||
                    (I_PADDR == `QSC_OFF_STATUS) ||
                    ((I_PADDR[11:4] == 8'(`QSC_OFF_RESULT0 >> 4)) &&
                     (I_PADDR[1:0] == 2'h0));
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
   assign O_PRDATA  = prdata_r;

   // control register
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         pdown_r   <= 1'b0;
         lane_m1_r <= 2'h0;
      end else if (wr_acc && I_PADDR == `QSC_OFF_CTRL) begin
         pdown_r   <= I_PWDATA[`QSC_CTRL_PDOWN_BIT];
         lane_m1_r <= I_PWDATA[`QSC_CTRL_LANE_MSB:`QSC_CTRL_LANE_LSB];
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         span_word_r <= `QSC_SPAN_RESET;
      end else if (wr_acc && I_PADDR == `QSC_OFF_SPAN) begin
         span_word_r <= I_PWDATA[11:0];
      end
   end

   // sticky result-ready flag, completion beats a clear
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ready_r <= 1'b0;
      end else if (commit) begin
         ready_r <= 1'b1;
      end else if (wr_acc && I_PADDR == `QSC_OFF_STATUS &&
                   I_PWDATA[`QSC_STAT_READY_BIT]) begin
         ready_r <= 1'b0;
      end
   end

   // read data captured in the setup cycle, valid in the access cycle
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         prdata_r <= 32'h0000_0000;
      end else if (I_PSEL && !I_PENABLE) begin
         prdata_r <= 32'h0000_0000;
         if (I_PADDR == `QSC_OFF_CTRL) begin
            prdata_r[`QSC_CTRL_PDOWN_BIT] <= pdown_r;
            prdata_r[`QSC_CTRL_LANE_MSB:`QSC_CTRL_LANE_LSB] <= lane_m1_r;
         end else if (I_PADDR == `QSC_OFF_SPAN) begin
            prdata_r[11:0] <= span_word_r;
         end else if (I_PADDR == `QSC_OFF_STATUS) begin
            prdata_r[`QSC_STAT_BUSY_BIT]  <=
               (state_r != qsc_pkg::QSC_ST_ACQ);
            prdata_r[`QSC_STAT_LVDS_BIT]  <= lvds_sync_r[1];
            prdata_r[`QSC_STAT_READY_BIT] <= ready_r;
         end else if (addr_ok) begin
            prdata_r[CODE_W-1:0] <= res_r[I_PADDR[3:2]];
            prdata_r[`QSC_RES_SPAN_MSB:`QSC_RES_SPAN_LSB] <=
               res_span_r[I_PADDR[3:2]];
         end
      end
   end

   // sequencer
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_r    <= qsc_pkg::QSC_ST_ACQ;
         span_lat_r <= 12'h000;
         ch_r       <= 3'h0;
         bit_r      <= 4'h0;
         code_r     <= 16'h0000;
         wait_r     <= 8'h00;
         hold_r     <= 1'b0;
         send_r     <= 2'h0;
      end else begin
         unique case (state_r)
            qsc_pkg::QSC_ST_ACQ: begin
               if (start_edge && !pdown_r) begin
                  hold_r     <= 1'b1;
                  span_lat_r <= span_word_r;
                  ch_r       <= 3'h0;
                  state_r    <= qsc_pkg::QSC_ST_PICK;
               end
            end
            // next channel onto the shared array
            qsc_pkg::QSC_ST_PICK: begin
               if (ch_r == 3'(NUM_CH)) begin
                  hold_r  <= 1'b0;
                  send_r  <= 2'h0;
                  state_r <= qsc_pkg::QSC_ST_SEND;
               end else if (cur_span == `QSC_SPAN_OFF) begin
                  ch_r <= ch_r + 3'h1;
               end else begin
                  code_r  <= `QSC_FIRST_TRIAL;
                  bit_r   <= 4'hF;
                  wait_r  <= 8'(SETTLE_CYC);
                  state_r <= qsc_pkg::QSC_ST_WAIT;
               end
            end
            // settle plus comparator synchroniser latency
            qsc_pkg::QSC_ST_WAIT: begin
               wait_r <= wait_r - 8'h01;
               if (wait_r == 8'h01) begin
                  state_r <= qsc_pkg::QSC_ST_DECIDE;
               end
            end
            // keep or drop the trial bit, try the next weight
            qsc_pkg::QSC_ST_DECIDE: begin
               if (bit_r == 4'h0) begin
                  code_r[0] <= cmp_s;
                  ch_r      <= ch_r + 3'h1;
                  state_r   <= qsc_pkg::QSC_ST_PICK;
               end else begin
                  code_r[bit_r]        <= cmp_s;
                  code_r[bit_r - 4'h1] <= 1'b1;
                  bit_r   <= bit_r - 4'h1;
                  wait_r  <= 8'(SETTLE_CYC);
                  state_r <= qsc_pkg::QSC_ST_WAIT;
               end
            end
            // channel 0 first, stalls on a full buffer
            qsc_pkg::QSC_ST_SEND: begin
               if (buf_in_ready) begin
                  send_r <= send_r + 2'h1;
                  if (send_r == 2'(NUM_CH - 1)) begin
                     state_r <= qsc_pkg::QSC_ST_ACQ;
                  end
               end
            end
         endcase
      end
   end

   // per-channel working and published results
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic [2:0] sp;
         assign sp = span_lat_r[g*3 +: 3];
         always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
            if (!I_RESETN) begin
               work_r[g] <= 16'h0000;
            end else if (state_r == qsc_pkg::QSC_ST_PICK &&
                         ch_r == 3'(g) && sp == `QSC_SPAN_OFF) begin
               work_r[g] <= 16'h0000;
            end else if (state_r == qsc_pkg::QSC_ST_DECIDE &&
                         ch_r == 3'(g) && bit_r == 4'h0) begin
               // bipolar spans have bit 1 set
               if (sp[1]) begin
                  work_r[g] <= {code_r[15:1], cmp_s} ^ `QSC_SIGN_FLIP;
               end else begin
                  work_r[g] <= {code_r[15:1], cmp_s};
               end
            end
         end
         // publish only once the whole set is done
         always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
            if (!I_RESETN) begin
               res_r[g]      <= 16'h0000;
               res_span_r[g] <= 3'h0;
            end else if (commit) begin
               res_r[g]      <= work_r[g];
               res_span_r[g] <= sp;
            end
         end
      end
   endgenerate

   // two-entry output buffer
   assign buf_in_ready = (buf_cnt_r != 2'(BUF_DEP));
   assign buf_push     = (state_r == qsc_pkg::QSC_ST_SEND) & buf_in_ready;
   assign buf_pop      = (buf_cnt_r != 2'h0) & I_OUT_READY;
   assign buf_in.chan  = send_r;
   assign buf_in.span  = res_span_r[send_r];
   assign buf_in.code  = res_r[send_r];

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         buf_wp_r  <= 1'b0;
         buf_rp_r  <= 1'b0;
         buf_cnt_r <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_wp_r <= ~buf_wp_r;
         end
         if (buf_pop) begin
            buf_rp_r <= ~buf_rp_r;
         end
         buf_cnt_r <= buf_cnt_r + 2'(buf_push) - 2'(buf_pop);
      end
   end

   generate
      for (g = 0; g < BUF_DEP; g++) begin : g_buf
         always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
            if (!I_RESETN) begin
               buf_mem[g] <= '0;
            end else if (buf_push && buf_wp_r == 1'(g)) begin
               buf_mem[g] <= buf_in;
            end
         end
      end
   endgenerate

   // outputs
   assign O_OUT_VALID  = (buf_cnt_r != 2'h0);
   assign O_OUT_WORD   = buf_mem[buf_rp_r];
   assign O_HOLD       = {NUM_CH{hold_r}};
   assign O_CH_SEL     = ch_r[1:0];
   assign O_CH_ATTACH  = (state_r == qsc_pkg::QSC_ST_WAIT) ||
                         (state_r == qsc_pkg::QSC_ST_DECIDE);
   assign O_DAC_CODE   = code_r;
   assign O_POWER_DOWN = pdown_r;
   assign O_LVDS_MODE  = lvds_sync_r[1];
   // lanes only matter in CMOS mode, LVDS uses one
   assign O_LANE_COUNT = lvds_sync_r[1] ? 3'h1 : {1'b0, lane_m1_r} + 3'h1;

endmodule

// ---- verification/qsc_seq_chk.sv ----
/*
 Port checker for the conversion sequencer.
 Assumes it is bound onto qsc_sequencer, one clock, async low reset.
*/
`timescale 1ns/1ps
module qsc_seq_chk #(
   parameter int NUM_CH = 4,
   parameter int CODE_W = 16
) (
   // clock and pins
   input wire logic               I_CLOCK,
   input wire logic               I_RESETN,
   input wire logic               I_LVDS_SEL,
   input wire logic               I_OUT_READY,
   // converter side
   input wire logic [NUM_CH-1:0]  O_HOLD,
   input wire logic [1:0]         O_CH_SEL,
   input wire logic               O_CH_ATTACH,
   input wire logic [CODE_W-1:0]  O_DAC_CODE,
   input wire logic               O_POWER_DOWN,
   // stream side
   input wire logic               O_OUT_VALID,
   input wire qsc_pkg::qsc_word_t O_OUT_WORD,
   input wire logic               O_LVDS_MODE,
   input wire logic [2:0]         O_LANE_COUNT
);
   logic [7:0] att_cnt_r;

   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESETN);

   // cycles attached, to bound the trial sequence
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) att_cnt_r <= 8'h00;
      else if (O_CH_ATTACH) att_cnt_r <= att_cnt_r + 8'h01;
      else att_cnt_r <= 8'h00;
   end

   property p_hold_all; O_HOLD == '0 || O_HOLD == '1; endproperty
   a_hold_all: assert property (p_hold_all)
      else $error("hold bits differ");
   property p_att_held; O_CH_ATTACH |-> O_HOLD == '1; endproperty
   a_att_held: assert property (p_att_held)
      else $error("attached while tracking");
   property p_sel; O_CH_ATTACH && $past(O_CH_ATTACH) |-> $stable(O_CH_SEL);
   endproperty
   a_sel: assert property (p_sel)
      else $error("channel moved while attached");
   property p_first; $rose(O_CH_ATTACH) |-> O_DAC_CODE == 16'h8000; endproperty
   a_first: assert property (p_first)
      else $error("first trial not half scale");
   property p_trials; $fell(O_CH_ATTACH) |-> att_cnt_r == 8'h60; endproperty
   a_trials: assert property (p_trials)
      else $error("trial sequence length wrong");
   property p_commit; $rose(O_OUT_VALID) |-> O_HOLD == '0 && !O_CH_ATTACH;
   endproperty
   a_commit: assert property (p_commit)
      else $error("output before conversion end");
   property p_mode; $stable(I_LVDS_SEL) [*3] |=>
      O_LVDS_MODE == $past(I_LVDS_SEL); endproperty
   a_mode: assert property (p_mode)
      else $error("mode does not follow pin");
   property p_lanes; O_LVDS_MODE |-> O_LANE_COUNT == 3'h1; endproperty
   a_lanes: assert property (p_lanes)
      else $error("lane count in lvds mode");
   property p_pdown; O_POWER_DOWN && O_HOLD == '0 |=> O_HOLD == '0;
   endproperty
   a_pdown: assert property (p_pdown)
      else $error("conversion started in power-down");
   property p_strm; O_OUT_VALID && !I_OUT_READY |=>
      O_OUT_VALID && $stable(O_OUT_WORD); endproperty
   a_strm: assert property (p_strm)
      else $error("stalled word lost or changed");
endmodule

bind qsc_sequencer qsc_seq_chk #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) u_chk (
   .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_LVDS_SEL(I_LVDS_SEL),
   .I_OUT_READY(I_OUT_READY), .O_HOLD(O_HOLD), .O_CH_SEL(O_CH_SEL),
   .O_CH_ATTACH(O_CH_ATTACH), .O_DAC_CODE(O_DAC_CODE),
   .O_POWER_DOWN(O_POWER_DOWN), .O_OUT_VALID(O_OUT_VALID),
   .O_OUT_WORD(O_OUT_WORD), .O_LVDS_MODE(O_LVDS_MODE),
   .O_LANE_COUNT(O_LANE_COUNT)
);

// ---- verification/qsc_cmp_model.sv ----
/*
 Behavioural sample-and-hold array and comparator.
 Assumes level inputs from the bench, one 16-bit value per channel.
*/
`timescale 1ns/1ps
module qsc_cmp_model (
   // sequencer side
   input wire logic        i_clock,
   input wire logic [3:0]  i_hold,
   input wire logic [1:0]  i_ch_sel,
   input wire logic        i_attach,
   input wire logic [15:0] i_dac_code,
   // analog side
   input wire logic [63:0] i_level,
   output logic            o_cmp_high
);
   logic [63:0] held_r;
   logic [15:0] sel;
   logic        junk_r = 1'b0;

   always @(posedge i_clock) begin
      junk_r <= ~junk_r;
      for (int k = 0; k < 4; k++) begin
         if (!i_hold[k]) held_r[16*k +: 16] <= i_level[16*k +: 16];
      end
   end
   assign sel = held_r[16*i_ch_sel +: 16];
   assign o_cmp_high = i_attach ? ({sel, 1'b1} > {i_dac_code, 1'b0}) : junk_r;
endmodule

// ---- verification/testbench.sv ----
/*
 Self-checking bench for the conversion sequencer.
 Assumes the comparator model stands on the analog side.
*/
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [11:0] span;
      logic [63:0] lvl;
   } qsc_row_t;
   logic               clk, rst_n, psel, pen, pwr, start, lvds, rdy;
   logic               pready, perr, pslverr, cmp, att, pdn, vld, lmode;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [3:0]         hold;
   logic [1:0]         chsel;
   logic [15:0]        dac;
   logic [2:0]         lanes;
   logic [63:0]        lvl;
   qsc_pkg::qsc_word_t word;
   int                 error_cnt, total_checks, cyc, n;
   qsc_row_t           rows [4];

   qsc_sequencer dut (
      .I_CLOCK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CONV_START(start),
      .I_LVDS_SEL(lvds), .I_CMP_HIGH(cmp), .O_HOLD(hold), .O_CH_SEL(chsel),
      .O_CH_ATTACH(att), .O_DAC_CODE(dac), .O_POWER_DOWN(pdn),
      .O_OUT_VALID(vld), .I_OUT_READY(rdy), .O_OUT_WORD(word),
      .O_LVDS_MODE(lmode), .O_LANE_COUNT(lanes)
   );
   qsc_cmp_model u_cmp (
      .i_clock(clk), .i_hold(hold), .i_ch_sel(chsel), .i_attach(att),
      .i_dac_code(dac), .i_level(lvl), .o_cmp_high(cmp)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report;
      end
   end

   task final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task start_conv;
      @(posedge clk);
      start <= 1'b1;
      repeat (4) @(posedge clk);
      start <= 1'b0;
   endtask

   function automatic logic [15:0] ecode(input logic [2:0] s,
                                         input logic [15:0] v);
      if (s == 3'h0) return 16'h0000;
      return s[1] ? v ^ 16'h8000 : v;
   endfunction

   task run_row(input qsc_row_t r, input int stall);
      logic [2:0] s;
      int         k;
      k = 0;
      n = 0;
      while (vld !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      repeat (stall) @(posedge clk);
      rdy <= 1'b1;
      while (k < 4 && n < 3000) begin
         @(posedge clk);
         n++;
         if (vld === 1'b1) begin
            s = r.span[3*k +: 3];
            chk({11'h0, word}, {11'h0, k[1:0], s, ecode(s, r.lvl[16*k +: 16])});
            k++;
         end
      end
      rdy <= 1'b0;
      chk(32'(k), 32'h4);
      for (k = 0; k < 4; k++) begin
         s = r.span[3*k +: 3];
         apb(1'b0, 12'h010 + 12'(4*k), 32'h0);
         chk(rd, {13'h0, s, ecode(s, r.lvl[16*k +: 16])});
      end
   endtask

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      start = 1'b0;
      lvds = 1'b0;
      rdy = 1'b0;
      lvl = 64'h0;
      rows[0] = '{12'h977, 64'h7FFF_8000_0000_FFFF};
      rows[1] = '{12'h053, 64'h1234_FFFE_7FFF_0001};
      rows[2] = '{12'h000, 64'h5555_5555_5555_5555};
      rows[3] = '{12'hBC8, 64'h0F0F_7FFE_8001_ABCD};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_0FFF);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk({31'h0, perr}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 12'h000, 32'(k << 2));
         repeat (2) @(posedge clk);
         chk({29'h0, lanes}, 32'(k + 1));
      end
      apb(1'b1, 12'h000, 32'h0);
      foreach (rows[i]) begin
         // levels must stand before the hold edge
         lvl <= rows[i].lvl;
         apb(1'b1, 12'h004, {20'h0, rows[i].span});
         start_conv;
         run_row(rows[i], 10);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd, 32'h4);
         apb(1'b1, 12'h008, 32'h4);
      end
      apb(1'b1, 12'h004, 32'h0000_0977);
      lvl <= rows[0].lvl;
      start_conv;
      // held samples must ignore later input moves
      lvl <= 64'h0;
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'h0007_FFFE);
      start_conv;
      run_row(rows[0], 0);
      repeat (500) @(posedge clk);
      chk({31'h0, vld}, 32'h0);
      apb(1'b1, 12'h008, 32'h4);
      apb(1'b1, 12'h000, 32'h1);
      start_conv;
      repeat (20) @(posedge clk);
      chk({27'h0, pdn, hold}, 32'h10);
      apb(1'b1, 12'h000, 32'hC);
      lvds <= 1'b1;
      repeat (6) @(posedge clk);
      chk({28'h0, lmode, lanes}, 32'h9);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h2);
      final_report;
   end
endmodule
